// >>> src/tocm_map.vh
// register offsets, field positions and encodings of the output-compare timer
`ifndef TOCM_MAP_VH
`define TOCM_MAP_VH
// documented offsets
`define TOCM_OFF_CNT 8'h24
`define TOCM_OFF_PSC 8'h28
`define TOCM_OFF_ARR 8'h2C
`define TOCM_OFF_CHAN1_COMPARE_VALUE 8'h34
`define TOCM_OFF_CCR2 8'h38
`define TOCM_OFF_CCR3 8'h3C
`define TOCM_OFF_CCR4 8'h40
`define TOCM_OFF_DCR 8'h48
`define TOCM_OFF_DMAR 8'h4C
`define TOCM_OFF_OR1 8'h50
`define TOCM_OFF_OR2 8'h60
// offsets of control registers without a printed address
`define TOCM_OFF_CTRL 8'h00
`define TOCM_OFF_MODE 8'h04
`define TOCM_OFF_STAT 8'h08
`define TOCM_OFF_EVGEN 8'h0C
// control register fields
`define TOCM_CTRL_EN 0
`define TOCM_CTRL_DIR 1
`define TOCM_CTRL_CMS 2
`define TOCM_CTRL_OPM 3
`define TOCM_CTRL_COMPARE_CONTROL_PRELOAD 4
`define TOCM_CTRL_POL 5
`define TOCM_CTRL_NPOL 6
`define TOCM_CTRL_LOCK_LO 8
`define TOCM_CTRL_LOCK_HI 9
`define TOCM_CTRL_REP_LO 16
`define TOCM_CTRL_REP_HI 23
// mode register fields: chan1 mode 3:0, chan2 mode 7:4, chan1 direction 9:8
`define TOCM_MODE1_LO 0
`define TOCM_MODE1_HI 3
`define TOCM_MODE2_LO 4
`define TOCM_MODE2_HI 7
`define TOCM_CCS_LO 8
`define TOCM_CCS_HI 9
// event generation bits
`define TOCM_EV_UG 0
`define TOCM_EV_TG 1
`define TOCM_EV_COMG 2
// status bits
`define TOCM_ST_UIF 0
`define TOCM_ST_TIF 1
`define TOCM_ST_DIR 2
// compare mode encodings
`define TOCM_M_FROZEN 4'h0
`define TOCM_M_SET 4'h1
`define TOCM_M_CLR 4'h2
`define TOCM_M_TOG 4'h3
`define TOCM_M_FLO 4'h4
`define TOCM_M_FHI 4'h5
`define TOCM_M_PWM1 4'h6
`define TOCM_M_PWM2 4'h7
`define TOCM_M_OPM1 4'h8
`define TOCM_M_OPM2 4'h9
`define TOCM_M_CPWM1 4'hC
`define TOCM_M_CPWM2 4'hD
`define TOCM_M_APWM1 4'hE
`define TOCM_M_APWM2 4'hF
// other constants
`define TOCM_LOCK3 2'h3
`define TOCM_CCS_OUT 2'h0
`define TOCM_ARR_RST 16'hFFFF
`endif

// >>> src/tocm_timer.v
// output-compare timer: counter, prescaler, update logic and channel 1/2 references
// Operation
// - mode 0000 freezes the reference
// - mode 0001 sets reference on match
// - mode 0010 clears reference on match
// - mode 0011 toggles reference on match
// - modes 0100/0101 force reference low/high
// - mode 0110 PWM1, direction dependent compare
// - mode 0111 PWM2, inverse of PWM1
// - mode 1000 retriggerable one-pulse, PWM1 shape
// - mode 1001 retriggerable one-pulse, PWM2 shape
// - mode 1100 combined reference is OR
// - mode 1101 combined reference is AND
// - modes 1110/1111 combined follows direction
// - outputs derived from reference with polarity
// - mode writes ignored at lock 3, output
// - PWM level changes only on compare change or on leaving frozen
// - mode preloaded, applied on commutation event
// - 16-bit prescaler divides by 1 to 65536
// - counter counts up, down or alternating
// - update event on overflow, underflow, reinit
// - repetition counter gates register updates
// - trigger event on trigger input rising edges
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "tocm_map.vh"
module tocm_timer #(
    parameter CW = 16,
    parameter RW = 8
) (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // trigger pin
    input wire trigger_input,
    // channel outputs and event pulses
    output reg chan1_reference,
    output reg chan2_reference,
    output reg chan1_combined_reference,
    output reg chan1_main_output,
    output reg chan1_complement_output,
    output reg update_event,
    output reg trigger_event
);
    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    reg [31:0] ctrl_q;
    reg [9:0] mode_pre_q;
    reg [7:0] mode_act_q;
    reg [CW-1:0] cnt_q, psc_q, psc_act_q, pcnt_q, arr_q, arr_act_q;
    reg [CW-1:0] chan1_compare_value_q, ccr2_q, ccr3_q, ccr4_q, chan1_compare_value_act_q, ccr2_act_q;
    reg [12:0] dcr_q;
    reg [15:0] dmar_q;
    reg [3:0] or1_q;
    reg [2:0] or2_q;
    reg [RW-1:0] rep_q;
    reg down_q, uif_q, tif_q, trg_s1_q, trg_s2_q, trg_s3_q;
    reg [1:0] armed_q; // one-pulse trigger seen, per channel
    reg [1:0] prev_cmp_q; // last PWM compare outcome, per channel
    reg [7:0] prev_mode_q;

    wire en = ctrl_q[`TOCM_CTRL_EN];
    wire cms = ctrl_q[`TOCM_CTRL_CMS];
    wire [1:0] lock = ctrl_q[`TOCM_CTRL_LOCK_HI:`TOCM_CTRL_LOCK_LO];
    wire [1:0] ccs = mode_pre_q[`TOCM_CCS_HI:`TOCM_CCS_LO];
    wire wr_cnt = reg_wr && reg_addr == `TOCM_OFF_CNT;
    wire wr_ev = reg_wr && reg_addr == `TOCM_OFF_EVGEN;
    wire ug = wr_ev && reg_wdata[`TOCM_EV_UG];
    wire comg = wr_ev && reg_wdata[`TOCM_EV_COMG];
    // trigger edge from the synchronised pin or software
    wire trg_edge = (trg_s2_q && !trg_s3_q) || (wr_ev && reg_wdata[`TOCM_EV_TG]);

    // -------------------------------------------------------------
    // counter core
    // -------------------------------------------------------------
    wire tick = en && (pcnt_q == psc_act_q); // prescaler wraps here
    wire at_top = (cnt_q == arr_act_q);
    wire at_bot = (cnt_q == {CW{1'b0}});
    wire ovf = tick && (cms ? (!down_q && at_top) : (!down_q && at_top));
    wire unf = tick && down_q && at_bot;
    wire cyc_end = ovf || unf;
    // cycle-end updates only after the programmed repetitions elapse
    wire upd = (cyc_end && rep_q == {RW{1'b0}}) || ug || trg_edge;
    wire rep_ld = upd;

    // prescaler, counter and shadow loads
    always @(posedge ref_clk) begin
        if (rst) begin
            pcnt_q <= {CW{1'b0}};
            cnt_q <= {CW{1'b0}};
            down_q <= 1'b0;
            rep_q <= {RW{1'b0}};
            psc_act_q <= {CW{1'b0}};
            arr_act_q <= `TOCM_ARR_RST;
            chan1_compare_value_act_q <= {CW{1'b0}};
            ccr2_act_q <= {CW{1'b0}};
        end else begin
            pcnt_q <= (tick || upd) ? {CW{1'b0}} : (en ? pcnt_q + 1'b1 : pcnt_q);
            if (rep_ld)
                rep_q <= ctrl_q[`TOCM_CTRL_REP_HI:`TOCM_CTRL_REP_LO];
            else if (cyc_end)
                rep_q <= rep_q - 1'b1;
            // new divider only at update, so a running change is glitch free
            if (upd) begin
                psc_act_q <= psc_q;
                arr_act_q <= arr_q;
                chan1_compare_value_act_q <= chan1_compare_value_q;
                ccr2_act_q <= ccr2_q;
            end
            if (wr_cnt) begin
                cnt_q <= reg_wdata[CW-1:0];
            end else if (ug || trg_edge) begin
                cnt_q <= down_q ? arr_act_q : {CW{1'b0}}; // reinit
            end else if (tick) begin
                if (cms) begin
                    if (!down_q && at_top) begin
                        down_q <= 1'b1;
                        cnt_q <= cnt_q - 1'b1;
                    end else if (down_q && at_bot) begin
                        down_q <= 1'b0;
                        cnt_q <= cnt_q + 1'b1;
                    end else begin
                        cnt_q <= down_q ? cnt_q - 1'b1 : cnt_q + 1'b1;
                    end
                end else begin
                    down_q <= ctrl_q[`TOCM_CTRL_DIR];
                    if (ctrl_q[`TOCM_CTRL_DIR])
                        cnt_q <= at_bot ? arr_act_q : cnt_q - 1'b1;
                    else
                        cnt_q <= at_top ? {CW{1'b0}} : cnt_q + 1'b1;
                end
            end
        end
    end

    // -------------------------------------------------------------
    // register writes
    // -------------------------------------------------------------
    // mode field locked while lock level 3 and channel is output
    wire mode_lock = (lock == `TOCM_LOCK3) && (ccs == `TOCM_CCS_OUT);
    always @(posedge ref_clk) begin
        if (rst) begin
            ctrl_q <= 32'h0000_0000;
            mode_pre_q <= 10'h000;
            psc_q <= {CW{1'b0}};
            arr_q <= `TOCM_ARR_RST;
            chan1_compare_value_q <= {CW{1'b0}};
            ccr2_q <= {CW{1'b0}};
            ccr3_q <= {CW{1'b0}};
            ccr4_q <= {CW{1'b0}};
            dcr_q <= 13'h0000;
            dmar_q <= 16'h0000;
            or1_q <= 4'h0;
            or2_q <= 3'h0;
        end else if (reg_wr) begin
            case (reg_addr)
                `TOCM_OFF_CTRL: ctrl_q <= reg_wdata;
                `TOCM_OFF_MODE: begin
                    if (!mode_lock)
                        mode_pre_q <= reg_wdata[9:0];
                    else
                        mode_pre_q[`TOCM_CCS_HI:`TOCM_CCS_LO] <=
                            reg_wdata[`TOCM_CCS_HI:`TOCM_CCS_LO];
                end
                `TOCM_OFF_PSC: psc_q <= reg_wdata[CW-1:0];
                `TOCM_OFF_ARR: arr_q <= reg_wdata[CW-1:0];
                `TOCM_OFF_CHAN1_COMPARE_VALUE: chan1_compare_value_q <= reg_wdata[CW-1:0];
                `TOCM_OFF_CCR2: ccr2_q <= reg_wdata[CW-1:0];
                `TOCM_OFF_CCR3: ccr3_q <= reg_wdata[CW-1:0];
                `TOCM_OFF_CCR4: ccr4_q <= reg_wdata[CW-1:0];
                `TOCM_OFF_DCR: dcr_q <= reg_wdata[12:0];
                `TOCM_OFF_DMAR: dmar_q <= reg_wdata[15:0];
                `TOCM_OFF_OR1: or1_q <= reg_wdata[3:0];
                `TOCM_OFF_OR2: or2_q <= reg_wdata[16:14];
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    // active mode: direct, or preloaded until commutation event
    always @(posedge ref_clk) begin
        if (rst)
            mode_act_q <= 8'h00;
        else if (!ctrl_q[`TOCM_CTRL_COMPARE_CONTROL_PRELOAD] || comg)
            mode_act_q <= mode_pre_q[7:0];
    end

    // -------------------------------------------------------------
    // status flags; hardware set wins over software clear
    // -------------------------------------------------------------
    wire clr_st = reg_wr && reg_addr == `TOCM_OFF_STAT;
    always @(posedge ref_clk) begin
        if (rst) begin
            uif_q <= 1'b0;
            tif_q <= 1'b0;
            trg_s1_q <= 1'b0;
            trg_s2_q <= 1'b0;
            trg_s3_q <= 1'b0;
            update_event <= 1'b0;
            trigger_event <= 1'b0;
        end else begin
            trg_s1_q <= trigger_input;
            trg_s2_q <= trg_s1_q;
            trg_s3_q <= trg_s2_q;
            update_event <= upd;
            trigger_event <= trg_edge;
            uif_q <= upd | (uif_q & ~(clr_st & reg_wdata[`TOCM_ST_UIF]));
            tif_q <= trg_edge | (tif_q & ~(clr_st & reg_wdata[`TOCM_ST_TIF]));
        end
    end

    // -------------------------------------------------------------
    // channel reference generation, one per channel
    // -------------------------------------------------------------
    wire [1:0] ref_d;
    wire [1:0] ref_q = {chan2_reference, chan1_reference};
    wire [1:0] cmp_now;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_ch
            wire [3:0] m = mode_act_q[4*g+3:4*g];
            wire [3:0] pm = prev_mode_q[4*g+3:4*g];
            wire [CW-1:0] ccr = g ? ccr2_act_q : chan1_compare_value_act_q;
            // one match per counter value, so a slow prescaler cannot toggle repeatedly
            wire match = en && (cnt_q == ccr) && (pcnt_q == {CW{1'b0}});
            // PWM1 level: up cnt<ccr high; down cnt>ccr low
            wire pwm1 = down_q ? !(cnt_q > ccr) : (cnt_q < ccr);
            wire pwm_mode = (m == `TOCM_M_PWM1) || (m == `TOCM_M_PWM2) || m[3];
            wire inv = m[0]; // PWM2 shapes are the inverse
            assign cmp_now[g] = pwm1 ^ inv;
            reg r;
            always @* begin
                r = ref_q[g];
                case (m)
                    `TOCM_M_SET: if (match) r = 1'b1;
                    `TOCM_M_CLR: if (match) r = 1'b0;
                    `TOCM_M_TOG: if (match) r = !ref_q[g];
                    `TOCM_M_FLO: r = 1'b0;
                    `TOCM_M_FHI: r = 1'b1;
                    `TOCM_M_PWM1, `TOCM_M_PWM2, `TOCM_M_CPWM1, `TOCM_M_CPWM2,
                    `TOCM_M_APWM1, `TOCM_M_APWM2: begin
                        // move only on outcome change or leaving frozen
                        if (cmp_now[g] != prev_cmp_q[g] || pm == `TOCM_M_FROZEN)
                            r = cmp_now[g];
                    end
                    `TOCM_M_OPM1, `TOCM_M_OPM2: begin
                        // idle level until trigger, then PWM shape
                        if (!armed_q[g])
                            r = down_q ? inv : !inv;
                        else
                            r = cmp_now[g];
                    end
                    default: r = ref_q[g]; // frozen and reserved hold
                endcase
            end
            assign ref_d[g] = r;
            always @(posedge ref_clk) begin
                if (rst) begin
                    armed_q[g] <= 1'b0;
                    prev_cmp_q[g] <= 1'b0;
                end else begin
                    prev_cmp_q[g] <= cmp_now[g];
                    // armed by trigger, disarmed at the next update
                    if (trg_edge)
                        armed_q[g] <= 1'b1;
                    else if (upd)
                        armed_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // combined reference of chan1 from both references
    reg comb_d;
    always @* begin
        case (mode_act_q[`TOCM_MODE1_HI:`TOCM_MODE1_LO])
            `TOCM_M_CPWM1: comb_d = ref_d[0] | ref_d[1];
            `TOCM_M_CPWM2: comb_d = ref_d[0] & ref_d[1];
            `TOCM_M_APWM1, `TOCM_M_APWM2: comb_d = down_q ? ref_d[1] : ref_d[0];
            default: comb_d = ref_d[0];
        endcase
    end

    // outputs straight from flops; polarity bit sets active level
    always @(posedge ref_clk) begin
        if (rst) begin
            chan1_reference <= 1'b0;
            chan2_reference <= 1'b0;
            chan1_combined_reference <= 1'b0;
            chan1_main_output <= 1'b0;
            chan1_complement_output <= 1'b0;
            prev_mode_q <= 8'h00;
        end else begin
            chan1_reference <= ref_d[0];
            chan2_reference <= ref_d[1];
            chan1_combined_reference <= comb_d;
            chan1_main_output <= comb_d ^ ctrl_q[`TOCM_CTRL_POL];
            chan1_complement_output <= !comb_d ^ ctrl_q[`TOCM_CTRL_NPOL];
            prev_mode_q <= mode_act_q;
        end
    end

    // -------------------------------------------------------------
    // read data, one cycle after the strobe; unmapped reads zero
    // -------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `TOCM_OFF_CTRL: reg_rdata <= ctrl_q;
                `TOCM_OFF_MODE: reg_rdata <= {22'h000000, mode_pre_q};
                `TOCM_OFF_STAT: reg_rdata <= {29'h00000000, down_q, tif_q, uif_q};
                `TOCM_OFF_CNT: reg_rdata <= {uif_q, 15'h0000, cnt_q};
                `TOCM_OFF_PSC: reg_rdata <= {16'h0000, psc_q};
                `TOCM_OFF_ARR: reg_rdata <= {16'h0000, arr_q};
                `TOCM_OFF_CHAN1_COMPARE_VALUE: reg_rdata <= {16'h0000, chan1_compare_value_q};
                `TOCM_OFF_CCR2: reg_rdata <= {16'h0000, ccr2_q};
                `TOCM_OFF_CCR3: reg_rdata <= {16'h0000, ccr3_q};
                `TOCM_OFF_CCR4: reg_rdata <= {16'h0000, ccr4_q};
                `TOCM_OFF_DCR: reg_rdata <= {19'h00000, dcr_q};
                `TOCM_OFF_DMAR: reg_rdata <= {16'h0000, dmar_q};
                `TOCM_OFF_OR1: reg_rdata <= {28'h0000000, or1_q};
                `TOCM_OFF_OR2: reg_rdata <= {15'h0000, or2_q, 14'h0000};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/tocm_chk_asserts.sv
// port-level assertion checker for the output-compare timer
`timescale 1ns/100ps
`default_nettype none
`include "tocm_map.vh"
module tocm_chk #(
    parameter CW = 16,
    parameter RW = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // pins
    input wire logic trigger_input,
    input wire logic chan1_reference,
    input wire logic chan2_reference,
    input wire logic chan1_combined_reference,
    input wire logic chan1_main_output,
    input wire logic chan1_complement_output,
    input wire logic update_event,
    input wire logic trigger_event
);
    logic [31:0] ctrl_q;
    logic [9:0] mode_q;
    logic [3:0] act_q;
    logic [3:0] act1_q;
    logic [3:0] act2_q;
    logic [1:0] up_q;
    // a locked output channel refuses mode writes
    wire ok = !(ctrl_q[9:8] == `TOCM_LOCK3 && mode_q[9:8] == `TOCM_CCS_OUT);
    // mode must have stood three samples, the design needs a cycle to apply it
    wire hold = act_q == act1_q && act1_q == act2_q;
    wire [3:0] m = act_q;
    // shadow of control and live mode, rebuilt from the register writes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_q <= 32'h0;
            mode_q <= 10'h0;
            act_q <= 4'h0;
            act1_q <= 4'h0;
            act2_q <= 4'h0;
            up_q <= 2'h0;
        end else begin
            act1_q <= act_q;
            act2_q <= act1_q;
            if (up_q != 2'h3)
                up_q <= up_q + 2'h1;
            if (reg_wr && reg_addr == `TOCM_OFF_CTRL)
                ctrl_q <= reg_wdata;
            if (reg_wr && reg_addr == `TOCM_OFF_MODE) begin
                mode_q[9:8] <= reg_wdata[9:8];
                if (ok)
                    mode_q[7:0] <= reg_wdata[7:0];
            end
            // live mode copies the preload each cycle unless preload control holds it
            if (!ctrl_q[`TOCM_CTRL_COMPARE_CONTROL_PRELOAD] || (reg_wr && reg_addr == `TOCM_OFF_EVGEN
                    && reg_wdata[`TOCM_EV_COMG]))
                act_q <= mode_q[3:0];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_frozen_hold: assert property (hold && (m == 4'h0 || m == 4'hA || m == 4'hB)
        |-> $stable(chan1_reference)) else $error("reference moved while frozen");
    a_force_level: assert property (hold && (m == `TOCM_M_FLO || m == `TOCM_M_FHI)
        |-> chan1_reference == m[0]) else $error("forced level wrong");
    a_set_no_fall: assert property (hold && m == `TOCM_M_SET
        |-> !$fell(chan1_reference)) else $error("reference fell in set mode");
    a_clr_no_rise: assert property (hold && m == `TOCM_M_CLR
        |-> !$rose(chan1_reference)) else $error("reference rose in clear mode");
    a_or_combine: assert property (hold && m == `TOCM_M_CPWM1 && $stable(chan1_reference)
        && $stable(chan2_reference) |-> chan1_combined_reference == (chan1_reference
        | chan2_reference)) else $error("combined or wrong");
    a_and_combine: assert property (hold && m == `TOCM_M_CPWM2 && $stable(chan1_reference)
        && $stable(chan2_reference) |-> chan1_combined_reference == (chan1_reference
        & chan2_reference)) else $error("combined and wrong");
    a_asym_follow: assert property (hold && m[3:1] == 3'h7 && !ctrl_q[2] && $stable(ctrl_q)
        && ctrl_q == $past(ctrl_q, 2) && $stable(chan1_reference) && $stable(chan2_reference)
        |-> chan1_combined_reference
        == (ctrl_q[1] ? chan2_reference : chan1_reference)) else $error("asymmetric wrong");
    a_pol_outputs: assert property (up_q == 2'h3 && $stable(chan1_combined_reference)
        && $stable(ctrl_q[6:5]) |-> chan1_main_output == (chan1_combined_reference ^ ctrl_q[5])
        && chan1_complement_output == (!chan1_combined_reference ^ ctrl_q[6]))
        else $error("output polarity wrong");
    a_trig_event: assert property ($rose(trigger_input) |-> ##[1:6] trigger_event)
        else $error("no trigger event");
    a_trig_single: assert property (trigger_event |=> !trigger_event)
        else $error("trigger event too long");
    a_upd_on_trig: assert property ($rose(trigger_input) |-> ##[1:8] update_event)
        else $error("no update on trigger");
    c_update: cover property (update_event);
    c_trigger: cover property (trigger_event);
    c_pwm_high: cover property (m == `TOCM_M_PWM1 && chan1_reference);
endmodule
`default_nettype wire

// >>> testbench/tocm_load.sv
// model of the circuitry on the channel pins: trigger source and edge counter
`timescale 1ns/100ps
`default_nettype none
module tocm_load (
    // clock and request from the bench
    input wire logic ref_clk,
    input wire logic fire,
    // timer pins
    input wire logic main_out,
    output logic trig_pin,
    // rising edges seen on the main output
    output int rises
);
    logic last_q = 1'b0;
    int len_q = 0;
    initial trig_pin = 1'b0;
    initial rises = 0;
    // pin held high four cycles so the slow synchroniser cannot miss it
    always @(posedge ref_clk) begin
        last_q <= main_out;
        if (main_out && !last_q)
            rises <= rises + 1;
        if (fire)
            len_q <= 4;
        else if (len_q > 0)
            len_q <= len_q - 1;
        trig_pin <= fire || len_q > 1;
    end
endmodule
`default_nettype wire

// >>> testbench/tb_timer_output_compare_modes.sv
// self-checking bench for the output-compare timer
`timescale 1ns/100ps
`default_nettype none
`include "tocm_map.vh"
module tb_timer_output_compare_modes;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic fire = 1'b0;
    wire [31:0] reg_rdata;
    wire trig, ch1, ch2, comb, mo, co, upd, tev;
    int rises, n, i, n_fail = 0, checks_done = 0;
    logic [31:0] d;
    // mode, ctrl, selected signal, expected high cycles in 40
    logic [31:0] tab [10] = '{32'h0601000C, 32'h0701001C, 32'h06030010, 32'h07030018,
        32'h6C010118, 32'h6D01010C, 32'h6E01010C, 32'h6E03011C, 32'h6F01011C, 32'h0601000C};
    tocm_timer tocm_timer_i (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .trigger_input(trig), .chan1_reference(ch1), .chan2_reference(ch2),
        .chan1_combined_reference(comb), .chan1_main_output(mo),
        .chan1_complement_output(co), .update_event(upd), .trigger_event(tev));
    tocm_load tocm_load_i (.ref_clk(ref_clk), .fire(fire), .main_out(mo), .trig_pin(trig),
        .rises(rises));
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // strobes stay one cycle; the idle edge after keeps drivers from double assigning
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
        @(posedge ref_clk);
    endtask
    task automatic cfg(input logic [7:0] mode, input logic [11:0] ctrl);
        wr(`TOCM_OFF_MODE, {24'h0, mode});
        wr(`TOCM_OFF_CTRL, {20'h0, ctrl});
        repeat (12) @(posedge ref_clk);
    endtask
    task automatic hi40(input logic sel);
        n = 0;
        repeat (40) begin
            @(negedge ref_clk);
            n += ((sel ? comb : ch1) === 1'b1);
        end
        @(posedge ref_clk);
    endtask
    // cycles between two update pulses, bounded so a dead counter cannot hang
    task automatic gap;
        i = 0;
        do @(negedge ref_clk); while (upd !== 1'b1 && ++i < 300);
        // the closing pulse edge is not counted by the loop, so start at one
        n = 1;
        do @(negedge ref_clk); while (upd !== 1'b1 && ++n < 300);
        @(posedge ref_clk);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        results();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk({mo, co}, 2'b01);
        rd(`TOCM_OFF_ARR, 32'h0000FFFF);
        rd(`TOCM_OFF_PSC, 32'h0);
        rd(8'h30, 32'h0);
        wr(`TOCM_OFF_ARR, 32'h9);
        wr(`TOCM_OFF_CHAN1_COMPARE_VALUE, 32'h3);
        wr(`TOCM_OFF_CCR2, 32'h6);
        rd(`TOCM_OFF_CHAN1_COMPARE_VALUE, 32'h3);
        wr(`TOCM_OFF_EVGEN, 32'h1);
        // the software update sets the update flag, whose copy rides in bit 31
        rd(`TOCM_OFF_CNT, 32'h80000000);
        // both forced levels through every polarity pair
        for (i = 0; i < 8; i++) begin
            cfg({7'h2, i[2]}, {5'h0, i[1:0], 5'h1});
            chk({mo, co}, {i[2] ^ i[0], !i[2] ^ i[1]});
        end
        foreach (tab[k]) begin
            cfg(tab[k][31:24], {4'h0, tab[k][23:16]});
            hi40(tab[k][8]);
            chk(n, tab[k][7:0]);
        end
        cfg(`TOCM_M_TOG, 12'h1);
        i = rises;
        repeat (40) @(posedge ref_clk);
        chk(rises - i, 2);
        cfg(`TOCM_M_FLO, 12'h1);
        cfg(`TOCM_M_SET, 12'h1);
        chk(ch1, 1'b1);
        cfg(`TOCM_M_CLR, 12'h1);
        chk(ch1, 1'b0);
        cfg(`TOCM_M_FHI, 12'h1);
        cfg(`TOCM_M_FROZEN, 12'h1);
        hi40(1'b0);
        chk(n, 40);
        cfg(`TOCM_M_FLO, 12'h1);
        cfg(8'h0A, 12'h1);
        hi40(1'b0);
        chk(n, 0);
        gap();
        chk(n, 10);
        wr(`TOCM_OFF_PSC, 32'h1);
        gap();
        gap();
        chk(n, 20);
        wr(`TOCM_OFF_CTRL, 32'h00020001);
        gap();
        gap();
        chk(n, 60);
        wr(`TOCM_OFF_PSC, 32'h0);
        wr(`TOCM_OFF_CTRL, 32'h1);
        gap();
        gap();
        // one-pulse shapes: armed by the trigger pin, disarmed by the update
        for (i = 0; i < 2; i++) begin
            cfg({7'h4, i[0]}, 12'h1);
            chk(ch1, !i[0]);
            fire <= 1'b1;
            @(posedge ref_clk);
            fire <= 1'b0;
            hi40(1'b0);
            chk(n, i[0] ? 7 : 33);
        end
        cfg(`TOCM_M_FLO, 12'h11);
        wr(`TOCM_OFF_MODE, 32'h5);
        repeat (3) @(posedge ref_clk);
        chk(ch1, 1'b0);
        wr(`TOCM_OFF_EVGEN, 32'h4);
        repeat (3) @(posedge ref_clk);
        chk(ch1, 1'b1);
        cfg(`TOCM_M_FLO, 12'h301);
        wr(`TOCM_OFF_MODE, 32'h5);
        repeat (3) @(posedge ref_clk);
        chk(ch1, 1'b0);
        results();
    end
endmodule
bind tocm_timer tocm_chk #(.CW(CW), .RW(RW)) tocm_chk_i (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trigger_input(trigger_input), .chan1_reference(chan1_reference),
    .chan2_reference(chan2_reference), .chan1_combined_reference(chan1_combined_reference),
    .chan1_main_output(chan1_main_output), .chan1_complement_output(chan1_complement_output),
    .update_event(update_event), .trigger_event(trigger_event));
`default_nettype wire
